/* File: design/efci_decoder.sv */
// Decode and execute logic for extended pointer-add, add-and-return, computed call and move.
`timescale 1ns/1ps
`default_nettype none
module efci_decoder
  import efci_pkg::*;
#(
  parameter int PTR_W = EFCI_PTR_W,
  parameter int PC_W  = EFCI_PC_W
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              extended_set_enable_bit,
  input  wire logic              instr_valid,
  input  wire logic [15:0]       instr_word,
  input  wire logic [7:0]        working_register,
  input  wire logic [7:0]        pc_high_latch,
  input  wire logic [7:0]        pc_upper_latch,
  input  wire logic [PC_W-1:0]   return_stack_top,
  input  wire logic [7:0]        mem_rdata,
  output logic [PTR_W-1:0]       indirect_pointer_0,
  output logic [PTR_W-1:0]       indirect_pointer_1,
  output logic [PTR_W-1:0]       indirect_pointer_2,
  output logic [PC_W-1:0]        pc,
  output logic                   pc_load,
  output logic                   stack_push,
  output logic [PC_W-1:0]        stack_push_data,
  output logic                   stack_pop,
  output logic [PTR_W-1:0]       mem_addr,
  output logic                   mem_rd,
  output logic                   mem_wr,
  output logic [7:0]             mem_wdata,
  output logic                   nop_cycle,
  output logic                   not_handled,
  output logic [1:0]             q_phase
);
  // One phase counter drives both decode and the phase output, so they cannot drift apart.
  efci_phase_if ph ();

  efci_phase_gen u_phase (
    .clk   (clk),
    .rst_b (rst_b),
    .ph    (ph)
  );

  // Every register of the decoder except the phase counter in u_phase lives in this one struct.
  typedef struct packed {
    efci_state_e            state;
    logic [PTR_W-1:0]       ptr0;
    logic [PTR_W-1:0]       ptr1;
    logic [PTR_W-1:0]       ptr2;
    logic [PC_W-1:0]        pc;
    logic                   pc_load;
    logic                   push;
    logic [PC_W-1:0]        push_data;
    logic                   pop;
    logic [PTR_W-1:0]       addr;
    logic                   rd;
    logic                   wr;
    logic [7:0]             wdata;
    logic                   nop;
    logic                   unhandled;
  } efci_state_s;

  efci_state_s s_q;
  efci_state_s s_d;

  logic [1:0]       sel;
  logic [7:0]       op_byte;
  logic [3:0]       op_nibble;
  logic [PTR_W-1:0] lit;
  logic [PTR_W-1:0] offset;
  logic             is_ptr_add;
  logic             is_return;
  logic             is_move;
  logic             is_call;
  logic [PC_W-1:0]  pc_next_word;
  logic [PC_W-1:0]  call_target;
  logic [PTR_W-1:0] move_src_addr;
  logic [PTR_W-1:0] move_dst_addr;

  // The top byte and selector are decoded once; extended forms die when the enable is low.
  assign op_byte    = instr_word[EFCI_OP_MSB:EFCI_OP_LSB];
  assign op_nibble  = instr_word[EFCI_OP_MSB:EFCI_NIB_LSB];
  assign sel        = instr_word[EFCI_SEL_MSB:EFCI_SEL_LSB];
  // Literals are zero-extended: the add is unsigned and moves a pointer down only by wrapping past the top.
  assign lit        = PTR_W'(instr_word[EFCI_LIT_MSB:0]);
  assign offset     = PTR_W'(instr_word[EFCI_OFS_MSB:0]);
  assign is_ptr_add = extended_set_enable_bit && (op_byte == EFCI_OP_PTR_ADD);
  assign is_return  = is_ptr_add && (sel == EFCI_SEL_RETURN);
  // The form bit set marks the indexed-to-indexed move, which is left to other logic.
  assign is_move    = extended_set_enable_bit && (op_byte == EFCI_OP_MOVE_1ST)
                      && !instr_word[EFCI_MOVE_FORM];
  // The whole word is compared, so a near miss is never taken for a call.
  assign is_call    = extended_set_enable_bit && (instr_word == EFCI_OP_CALL_W);

  // Pointer-add and move words step the counter by one word, kept at the counter's width.
  assign pc_next_word  = s_q.pc + PC_W'(EFCI_PC_STEP);
  // Upper latch bits above the counter width are dropped; the counter cannot hold them.
  assign call_target   = {pc_upper_latch[PC_W-2*EFCI_BYTE_W-1:0], pc_high_latch,
                          working_register};
  // The sum stays PTR_W wide so it wraps across the byte boundary.
  assign move_src_addr = s_q.ptr2 + offset;
  assign move_dst_addr = instr_word[PTR_W-1:0];

  always_comb begin
    // Pulse fields default low so none can stretch past one clock.
    s_d           = s_q;
    s_d.pc_load   = 1'b0;
    s_d.push      = 1'b0;
    s_d.pop       = 1'b0;
    s_d.rd        = 1'b0;
    s_d.wr        = 1'b0;
    s_d.nop       = 1'b0;
    s_d.unhandled = 1'b0;
    // Everything happens at the last phase so a word is taken once per instruction cycle.
    if (ph.last_phase) begin
      case (s_q.state)
        EFCI_ST_EXEC: begin
          if (instr_valid) begin
            if (is_return) begin
              // Pointer and counter change together; no status is touched.
              s_d.ptr2    = s_q.ptr2 + lit;
              s_d.pc      = return_stack_top;
              s_d.pc_load = 1'b1;
              s_d.pop     = 1'b1;
              s_d.state   = EFCI_ST_NOP;
            end else if (is_ptr_add) begin
              // Sums stay PTR_W wide so they wrap across the byte boundary.
              case (sel)
                EFCI_PTR0: s_d.ptr0 = s_q.ptr0 + lit;
                EFCI_PTR1: s_d.ptr1 = s_q.ptr1 + lit;
                default:   s_d.ptr2 = s_q.ptr2 + lit;
              endcase
              s_d.pc = pc_next_word;
            end else if (is_call) begin
              // The return address is the word after the call, taken before the counter moves.
              s_d.push      = 1'b1;
              s_d.push_data = pc_next_word;
              // Only the program counter changes; working, status and bank stay put.
              s_d.pc        = call_target;
              s_d.pc_load   = 1'b1;
              s_d.state     = EFCI_ST_NOP;
            end else if (is_move) begin
              s_d.addr  = move_src_addr;
              s_d.rd    = 1'b1;
              s_d.pc    = pc_next_word;
              s_d.state = EFCI_ST_MOVE;
            end else begin
              // Anything else belongs to other decode logic and is only flagged here.
              s_d.unhandled = 1'b1;
            end
          end
        end
        EFCI_ST_NOP: begin
          // The word fetched here belongs to the abandoned path, so it is dropped unseen.
          s_d.nop   = 1'b1;
          s_d.state = EFCI_ST_EXEC;
        end
        EFCI_ST_MOVE: begin
          // The source byte was read at the end of the first word's cycle.
          if (instr_valid && op_nibble == EFCI_OP_MOVE_2ND) begin
            s_d.addr  = move_dst_addr;
            s_d.wdata = mem_rdata;
            s_d.wr    = 1'b1;
            s_d.pc    = pc_next_word;
          end else begin
            // A missing second word abandons the move rather than write to a guessed address.
            s_d.unhandled = 1'b1;
          end
          s_d.state = EFCI_ST_EXEC;
        end
        default: s_d.state = EFCI_ST_EXEC;
      endcase
    end
  end

  // Reset is asynchronous so a half-done move or idle cycle never survives it.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Pointers and counter restart from their reset values; pulses and state clear.
      s_q       <= '0;
      s_q.state <= EFCI_ST_EXEC;
      s_q.pc    <= EFCI_PC_RESET;
      s_q.ptr0  <= EFCI_PTR_RESET;
      s_q.ptr1  <= EFCI_PTR_RESET;
      s_q.ptr2  <= EFCI_PTR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output comes straight from a flop, so none can glitch while phases step.
  assign indirect_pointer_0 = s_q.ptr0;
  assign indirect_pointer_1 = s_q.ptr1;
  assign indirect_pointer_2 = s_q.ptr2;
  assign pc                 = s_q.pc;
  assign pc_load            = s_q.pc_load;
  assign stack_push         = s_q.push;
  assign stack_push_data    = s_q.push_data;
  assign stack_pop          = s_q.pop;
  assign mem_addr           = s_q.addr;
  assign mem_rd             = s_q.rd;
  assign mem_wr             = s_q.wr;
  assign mem_wdata          = s_q.wdata;
  assign nop_cycle          = s_q.nop;
  assign not_handled        = s_q.unhandled;
  assign q_phase            = ph.phase;
endmodule : efci_decoder
`default_nettype wire

/* File: design/efci_phase_gen.sv */
// Four-phase instruction cycle generator.
`timescale 1ns/1ps
`default_nettype none
module efci_phase_gen
  import efci_pkg::*;
(
  input wire logic    clk,
  input wire logic    rst_b,
  efci_phase_if.gen   ph
);
  typedef struct packed {
    logic [1:0] phase;
  } efci_phase_s;

  efci_phase_s s_q;
  efci_phase_s s_d;

  always_comb begin
    s_d       = s_q;
    s_d.phase = s_q.phase + 2'h1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ph.phase      = s_q.phase;
  assign ph.last_phase = (s_q.phase == EFCI_Q_LAST);
endmodule : efci_phase_gen
`default_nettype wire

/* File: design/efci_phase_if.sv */
// Interface carrying the four-phase instruction cycle timing between modules.
`timescale 1ns/1ps
`default_nettype none
interface efci_phase_if;
  logic [1:0] phase;
  logic       last_phase;
  modport gen (output phase, output last_phase);
  modport use_ (input phase, input last_phase);
endinterface : efci_phase_if
`default_nettype wire

/* File: design/efci_pkg.sv */
// Package of encodings, widths and state codes for the extended pointer and call decoder.
package efci_pkg;
  localparam int         EFCI_PTR_W       = 12;
  localparam int         EFCI_PC_W        = 21;
  localparam logic [7:0] EFCI_OP_PTR_ADD  = 8'hE8;
  localparam logic [7:0] EFCI_OP_MOVE_1ST = 8'hEB;
  localparam logic [3:0] EFCI_OP_MOVE_2ND = 4'hF;
  localparam logic [15:0] EFCI_OP_CALL_W  = 16'h0014;
  localparam logic [1:0] EFCI_SEL_RETURN  = 2'h3;
  localparam logic [1:0] EFCI_PTR2        = 2'h2;
  localparam logic [1:0] EFCI_Q_LAST      = 2'h3;
  localparam logic [20:0] EFCI_PC_STEP    = 21'h000002;
  localparam logic [20:0] EFCI_PC_RESET   = 21'h000000;
  localparam logic [11:0] EFCI_PTR_RESET  = 12'h000;
  localparam int          EFCI_OP_MSB     = 15;
  localparam int          EFCI_OP_LSB     = 8;
  localparam int          EFCI_NIB_LSB    = 12;
  localparam int          EFCI_SEL_MSB    = 7;
  localparam int          EFCI_SEL_LSB    = 6;
  localparam int          EFCI_LIT_MSB    = 5;
  localparam int          EFCI_OFS_MSB    = 6;
  localparam int          EFCI_MOVE_FORM  = 7;
  localparam int          EFCI_BYTE_W     = 8;
  localparam logic [1:0]  EFCI_PTR0       = 2'h0;
  localparam logic [1:0]  EFCI_PTR1       = 2'h1;

  typedef enum logic [1:0] {
    EFCI_ST_EXEC = 2'b00,
    EFCI_ST_NOP  = 2'b01,
    EFCI_ST_MOVE = 2'b10
  } efci_state_e;
endpackage : efci_pkg

/* File: test/efci_decoder_props.sv */
// Concurrent checks on the ports of the extended pointer and call decoder.
`timescale 1ns/1ps
`default_nettype none
module efci_decoder_props
  import efci_pkg::*;
#(
  parameter int PTR_W = EFCI_PTR_W,
  parameter int PC_W  = EFCI_PC_W
) (
  input wire logic             clk,
  input wire logic             rst_b,
  input wire logic             extended_set_enable_bit,
  input wire logic             instr_valid,
  input wire logic [15:0]      instr_word,
  input wire logic [7:0]       working_register,
  input wire logic [7:0]       pc_high_latch,
  input wire logic [7:0]       pc_upper_latch,
  input wire logic [PC_W-1:0]  return_stack_top,
  input wire logic [7:0]       mem_rdata,
  input wire logic [PTR_W-1:0] indirect_pointer_0,
  input wire logic [PTR_W-1:0] indirect_pointer_2,
  input wire logic [PC_W-1:0]  pc,
  input wire logic             pc_load,
  input wire logic             stack_push,
  input wire logic [PC_W-1:0]  stack_push_data,
  input wire logic             stack_pop,
  input wire logic [PTR_W-1:0] mem_addr,
  input wire logic             mem_rd,
  input wire logic             mem_wr,
  input wire logic [7:0]       mem_wdata,
  input wire logic             nop_cycle,
  input wire logic             not_handled,
  input wire logic [1:0]       q_phase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic busy;
  // A call, return or move first word makes the word one slot later not a fresh one.
  assign busy = stack_push || stack_pop || mem_rd;
  // A word counts as fresh only if no call, return or move first word came one cycle before.
  sequence take_s;
    q_phase == 2'h3 && instr_valid && extended_set_enable_bit
      && !$past(busy, 3);
  endsequence
  sequence call_s;
    take_s ##0 instr_word == EFCI_OP_CALL_W;
  endsequence
  sequence ret_s;
    take_s ##0 instr_word[15:6] == {EFCI_OP_PTR_ADD, EFCI_SEL_RETURN};
  endsequence
  AST_PTR_ADD: assert property (take_s ##0 instr_word[15:6] == {EFCI_OP_PTR_ADD, 2'h0} |=>
    indirect_pointer_0 == $past(indirect_pointer_0) + $past(instr_word[5:0])
    && pc == $past(pc) + EFCI_PC_STEP && !pc_load) else $error("pointer add wrong");
  AST_RET: assert property (ret_s |=> stack_pop && pc_load && pc == $past(return_stack_top)
    && indirect_pointer_2 == $past(indirect_pointer_2) + $past(instr_word[5:0]))
    else $error("add and return wrong");
  AST_RET_NOP: assert property (ret_s |=> ##3 !nop_cycle ##1 nop_cycle)
    else $error("no idle cycle after return");
  AST_CALL: assert property (call_s |=> stack_push && pc_load
    && stack_push_data == $past(pc) + EFCI_PC_STEP && pc == {$past(pc_upper_latch[4:0]),
    $past(pc_high_latch), $past(working_register)}) else $error("computed call wrong");
  AST_CALL_NOP: assert property (call_s |=> !nop_cycle [*4] ##1 nop_cycle)
    else $error("no idle cycle after call");
  AST_MOVE_RD: assert property (take_s ##0 instr_word[15:7] == {EFCI_OP_MOVE_1ST, 1'b0} |=>
    mem_rd && !mem_wr && mem_addr == $past(indirect_pointer_2) + $past(instr_word[6:0]))
    else $error("move source wrong");
  AST_MOVE_WR: assert property (mem_rd ##3 (q_phase == 2'h3 && instr_valid
    && extended_set_enable_bit && instr_word[15:12] == EFCI_OP_MOVE_2ND) |=> mem_wr
    && mem_addr == $past(instr_word[11:0]) && mem_wdata == $past(mem_rdata))
    else $error("move destination wrong");
  AST_DISABLED: assert property (q_phase == 2'h3 && instr_valid && !extended_set_enable_bit
    && !$past(busy, 3) |=> not_handled && !pc_load && $stable(pc))
    else $error("decoding while disabled");
endmodule : efci_decoder_props
`default_nettype wire

/* File: test/efci_tb_top.sv */
// Self-checking bench for the extended pointer and call decoder.
`timescale 1ns/1ps
`default_nettype none
module efci_tb_top
  import efci_pkg::*;
;
  logic        clk = 1'b0, rst_b = 1'b0, extended_set_enable_bit = 1'b1, instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0]  working_register = 8'h00, pc_high_latch = 8'h00, pc_upper_latch = 8'h00;
  logic [7:0]  mem_rdata = 8'h00, mem_wdata;
  logic [20:0] return_stack_top = 21'h000000, pc, stack_push_data, epc;
  logic [11:0] indirect_pointer_0, indirect_pointer_1, indirect_pointer_2, mem_addr;
  logic [11:0] ptr [3];
  logic        pc_load, stack_push, stack_pop, mem_rd, mem_wr, nop_cycle, not_handled;
  logic [1:0]  q_phase, f;
  logic [5:0]  k;
  int          errors = 0, checked = 0, seed = 97, i;

  efci_decoder efci_decoder_i (.clk, .rst_b, .extended_set_enable_bit, .instr_valid,
    .instr_word, .working_register, .pc_high_latch, .pc_upper_latch, .return_stack_top,
    .mem_rdata, .indirect_pointer_0, .indirect_pointer_1, .indirect_pointer_2, .pc, .pc_load,
    .stack_push, .stack_push_data, .stack_pop, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
    .nop_cycle, .not_handled, .q_phase);

  always #2 clk = ~clk;

  function automatic logic [11:0] padd(input logic [11:0] p, input logic [6:0] n);
    return p + 12'(n);
  endfunction : padd

  task automatic chk_v(input string what, input logic [20:0] exp, input logic [20:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_v

  task automatic chk_p(input string what, input logic exp, input logic got);
    chk_v(what, {20'h00000, exp}, {20'h00000, got});
  endtask : chk_p

  task automatic chk_state();
    chk_v("pc", epc, pc);
    chk_v("pointer 0", 21'(ptr[0]), 21'(indirect_pointer_0));
    chk_v("pointer 1", 21'(ptr[1]), 21'(indirect_pointer_1));
    chk_v("pointer 2", 21'(ptr[2]), 21'(indirect_pointer_2));
  endtask : chk_state

  // Inputs change at the edge that ends phase 2, so they are steady at the taking edge.
  task automatic run(input logic [15:0] w, input logic e = 1'b1);
    do @(negedge clk); while (q_phase !== 2'h2);
    @(posedge clk);
    instr_word <= w;
    instr_valid <= 1'b1;
    extended_set_enable_bit <= e;
    {working_register, pc_high_latch, pc_upper_latch, mem_rdata} <= $random(seed);
    return_stack_top <= 21'($random(seed));
    @(posedge clk);
    @(negedge clk);
    chk_v("phase", 21'h000000, 21'(q_phase));
  endtask : run

  task automatic report_and_stop();
    $display("Comparisons %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #20000;
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    epc = EFCI_PC_RESET;
    ptr = '{3{EFCI_PTR_RESET}};
    @(negedge clk);
    chk_state();
    // Enough literals, every second one maximum-size, go in for every pointer to wrap past the top.
    for (i = 0; i < 300; i++) begin
      f = (i < 3) ? 2'(i) : 2'($unsigned($random(seed)) % 3);
      k = i[0] ? 6'h3F : 6'($random(seed));
      run({EFCI_OP_PTR_ADD, f, k});
      ptr[f] = padd(ptr[f], {1'b0, k});
      epc += EFCI_PC_STEP;
      chk_state();
    end
    run(EFCI_OP_CALL_W);
    chk_p("push", 1'b1, stack_push);
    chk_v("push data", epc + EFCI_PC_STEP, stack_push_data);
    epc = {pc_upper_latch[4:0], pc_high_latch, working_register};
    chk_p("load", 1'b1, pc_load);
    chk_state();
    run(EFCI_OP_CALL_W);
    chk_p("idle", 1'b1, nop_cycle);
    chk_p("push", 1'b0, stack_push);
    run({EFCI_OP_PTR_ADD, EFCI_SEL_RETURN, 6'h2A});
    ptr[2] = padd(ptr[2], 7'h2A);
    epc = return_stack_top;
    chk_p("pop", 1'b1, stack_pop);
    chk_state();
    run({EFCI_OP_PTR_ADD, 2'h0, 6'h01});
    chk_p("idle", 1'b1, nop_cycle);
    chk_state();
    run({EFCI_OP_PTR_ADD, 2'h1, 6'h3F}, 1'b0);
    chk_p("unhandled", 1'b1, not_handled);
    chk_state();
    run(16'h0015);
    chk_p("unhandled", 1'b1, not_handled);
    run({EFCI_OP_MOVE_1ST, 1'b0, 7'h7F});
    epc += EFCI_PC_STEP;
    chk_p("read", 1'b1, mem_rd);
    chk_v("source", 21'(padd(ptr[2], 7'h7F)), 21'(mem_addr));
    run({EFCI_OP_MOVE_2ND, 12'hFFF});
    epc += EFCI_PC_STEP;
    chk_p("write", 1'b1, mem_wr);
    chk_v("dest", 21'h000FFF, mem_addr);
    chk_v("data", 21'(mem_rdata), 21'(mem_wdata));
    chk_state();
    // A second reset in mid-run must bring back the counter and all three pointers and restart the phases.
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    epc = EFCI_PC_RESET;
    ptr = '{3{EFCI_PTR_RESET}};
    @(negedge clk);
    chk_state();
    chk_v("phase", 21'h000000, 21'(q_phase));
    run({EFCI_OP_PTR_ADD, 2'h1, 6'h05});
    ptr[1] = padd(ptr[1], 7'h05);
    epc += EFCI_PC_STEP;
    chk_state();
    report_and_stop();
  end
endmodule : efci_tb_top

bind efci_decoder efci_decoder_props #(.PTR_W(PTR_W), .PC_W(PC_W)) efci_decoder_props_i (
  .clk, .rst_b, .extended_set_enable_bit, .instr_valid, .instr_word, .working_register,
  .pc_high_latch, .pc_upper_latch, .return_stack_top, .mem_rdata, .indirect_pointer_0,
  .indirect_pointer_2, .pc, .pc_load, .stack_push, .stack_push_data, .stack_pop, .mem_addr,
  .mem_rd, .mem_wr, .mem_wdata, .nop_cycle, .not_handled, .q_phase);
`default_nettype wire
